// *** rtl/seq_pkg.sv ***
// Purpose: shared constants for the operating state sequencer
// Assumes: bytes arrive already deframed from the serial link
// Notes: text tables are plain ascii, first byte in the top bits
//
// What this block does
// - restart always enters the loader state first
// - loader state uses fixed 115200 baud
// - loader waits at least three seconds, then leaves
// - mode pin held low keeps loader state
// - hold command with one locks loader state
// - restart-to-loader in setup locks loader state
// - leave loader only with firmware integrity confirmed
// - every run entry sends the operating-begin notice
// - run state uses stored baud and streams data
// - pin low or setup command enters setup
// - operating-end at stored baud, setup-begin at fixed
// - setup stops streaming, fixed baud, accepts commands
// - leaving setup saves settings to nonvolatile memory
// - pin release or setup zero returns to run
// - setup-end at fixed baud, then operating-begin stored
// - restart commands in setup reach loader state
// - loader entry sends the loader-begin notice
// - hold command also locks the setup state
// - active low reset pin restarts into loader
// - commands need line feed or return terminator
// - loader needs upper case, setup folds case
package seq_pkg;

  typedef enum logic [1:0] {OP_LOADER, OP_RUN, OP_SETUP} op_e;
  typedef enum logic [1:0] {PH_IDLE, PH_END, PH_BEGIN} ph_e;
  typedef enum logic [2:0] {
    NT_LOADER_BEGIN, NT_OPER_BEGIN, NT_OPER_END, NT_SETUP_BEGIN,
    NT_SETUP_END
  } notice_e;

  // loader window timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned LOADER_WINDOW_MS = 3000;
  localparam int unsigned LOADER_WINDOW_CYC_DEF =
    CLK_HZ / 1000 * LOADER_WINDOW_MS;

  // baud setting code 0 is the fixed 115200 rate
  localparam logic [1:0] BAUD_FIXED = 2'h0;

  // characters
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7a;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [4:0] PREFIX_LEN = 5'h03;
  localparam logic [4:0] POS_MAX = 5'h1f;

  // command table, text after the common prefix
  localparam int NUM_CMD = 6;
  localparam int CMD_MAX = 18;
  localparam int CMD_HOLD_ON = 0;
  localparam int CMD_HOLD_OFF = 1;
  localparam int CMD_SETUP_ON = 2;
  localparam int CMD_SETUP_OFF = 3;
  localparam int CMD_RESTART_LDR = 4;
  localparam int CMD_RESTART = 5;
  localparam logic [8*CMD_MAX-1:0] CMD_TEXT [NUM_CMD] = '{
    144'h4c4f_434b_3d31_0000_0000_0000_0000_0000_0000,
    144'h4c4f_434b_3d30_0000_0000_0000_0000_0000_0000,
    144'h434f_4e46_4947_3d31_0000_0000_0000_0000_0000,
    144'h434f_4e46_4947_3d30_0000_0000_0000_0000_0000,
    144'h5245_424f_4f54_5f42_4f4f_544c_4f41_4445_5200,
    144'h5245_424f_4f54_0000_0000_0000_0000_0000_0000
  };
  localparam logic [4:0] CMD_LEN [NUM_CMD] = '{
    5'h06, 5'h06, 5'h08, 5'h08, 5'h11, 5'h06
  };

  // notice bodies, framed by the prefix and cr lf
  localparam int NUM_NOTICE = 5;
  localparam logic [127:0] NOTICE_TEXT [NUM_NOTICE] = '{
    128'h424f_4f54_4c4f_4144_4552_5f53_5441_5254,
    128'h5255_4e5f_5354_4152_5400_0000_0000_0000,
    128'h5255_4e5f_454e_4400_0000_0000_0000_0000,
    128'h434f_4e46_4947_5f53_5441_5254_0000_0000,
    128'h434f_4e46_4947_5f45_4e44_0000_0000_0000
  };
  localparam logic [4:0] NOTICE_LEN [NUM_NOTICE] = '{
    5'h10, 5'h09, 5'h07, 5'h0c, 5'h0a
  };
  localparam logic [4:0] FRAME_EXTRA = 5'h05;

endpackage : seq_pkg

// *** rtl/cmd_line_parser.sv ***
// Purpose: matches terminated command lines against the command table
// Assumes: one byte per valid cycle, no back-pressure needed
// Notes: a match is reported one cycle after its terminator
`timescale 1ns/1ns
`default_nettype none
module cmd_line_parser
  import seq_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // received bytes
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic fold_case_i,
  // one-hot command pulses
  output logic [NUM_CMD-1:0] cmd_o
);

  logic [4:0] pos_q, pos_d;
  logic [NUM_CMD-1:0] hit_q, hit_d, cmd_q, cmd_d, char_ok, len_ok;
  logic [7:0] ch;
  logic term, pre_ok;
  logic [4:0] body_pos;

  // body byte lookup, zero past the end so it never matches text
  function automatic logic [7:0] body_byte(int c, logic [4:0] i);
    logic [7:0] b;
    b = 8'h00;
    if (int'(i) < CMD_MAX) begin
      b = CMD_TEXT[c][8*CMD_MAX-1-8*int'(i) -: 8];
    end
    return b;
  endfunction : body_byte

  assign body_pos = pos_q - PREFIX_LEN;

  // per command compare against the current position
  for (genvar c = 0; c < NUM_CMD; c++) begin : g_cmd
    assign char_ok[c] = (pos_q < PREFIX_LEN) ||
                        (ch == body_byte(c, body_pos));
    assign len_ok[c] = (pos_q == PREFIX_LEN + CMD_LEN[c]);
  end

  // line tracking; prefix is always exact, letters fold only in setup
  always_comb begin
    ch = byte_i;
    if (fold_case_i && byte_i >= CH_LOW_A && byte_i <= CH_LOW_Z) begin
      ch = byte_i - CASE_BIT;
    end
    term = (byte_i == CH_LF) || (byte_i == CH_CR);
    unique case (pos_q)
      5'h00: pre_ok = (byte_i == CH_A);
      5'h01: pre_ok = (byte_i == CH_T);
      5'h02: pre_ok = (byte_i == CH_PLUS);
      default: pre_ok = 1'b1;
    endcase
    pos_d = pos_q;
    hit_d = hit_q;
    cmd_d = '0;
    if (byte_valid_i) begin
      if (term) begin
        // cr lf gives an empty second line, which matches nothing
        pos_d = '0;
        hit_d = '1;
        cmd_d = hit_q & len_ok;
      end else begin
        if (pos_q != POS_MAX) begin
          pos_d = pos_q + 5'h01;
        end
        hit_d = hit_q & char_ok & {NUM_CMD{pre_ok}};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pos_q <= '0;
      hit_q <= '1;
      cmd_q <= '0;
    end else begin
      pos_q <= pos_d;
      hit_q <= hit_d;
      cmd_q <= cmd_d;
    end
  end

  assign cmd_o = cmd_q;

  property p_term_only;
    @(posedge clk_i) disable iff (sys_rst_i)
    (|cmd_q) |-> $past(byte_valid_i && (byte_i == CH_LF ||
                                        byte_i == CH_CR));
  endproperty
  a_term_only: assert property (p_term_only)
    else $error("command reported without a terminator");

  property p_upper_only;
    @(posedge clk_i) disable iff (sys_rst_i)
    (byte_valid_i && !fold_case_i && byte_i >= CH_LOW_A &&
     byte_i <= CH_LOW_Z) |=> (hit_q == '0);
  endproperty
  a_upper_only: assert property (p_upper_only)
    else $error("lower case letter kept a loader command alive");

endmodule : cmd_line_parser
`default_nettype wire

// *** rtl/operating_state_sequencer.sv ***
// Purpose: loader, run and setup state control with text notices
// Assumes: serial framing and nonvolatile storage live outside
// Notes: the loader window is a parameter so simulation can shorten it
`timescale 1ns/1ns
`default_nettype none
module operating_state_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned LOADER_WINDOW_CYC = LOADER_WINDOW_CYC_DEF
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic module_rst_n_i,
  // mode select pin, low asks for loader or setup
  input wire logic mode_sel_i,
  // firmware check result and stored baud setting
  input wire logic fw_ok_i,
  input wire logic [1:0] stored_baud_i,
  // received command bytes
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // notice bytes towards the serial transmitter
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // status and control towards the rest of the receiver
  output logic [1:0] baud_sel_o,
  output logic [1:0] op_state_o,
  output logic lock_o,
  output logic stream_en_o,
  output logic nvm_save_o,
  output logic settings_load_o
);

  localparam int TW = $clog2(LOADER_WINDOW_CYC + 1);
  localparam logic [TW-1:0] WIN_END = TW'(LOADER_WINDOW_CYC);

  logic rst;
  op_e mode_q, mode_d, tgt_q, tgt_d;
  ph_e phase_q, phase_d;
  notice_e ntc_q, ntc_d;
  logic [4:0] bi_q, bi_d, total;
  logic tx_valid_q, tx_valid_d;
  logic [7:0] tx_data_q, tx_data_d, next_byte;
  logic lock_q, lock_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic win_done;
  logic [1:0] baud_q, baud_d;
  logic stream_q, stream_d, save_q, save_d, load_q, load_d;
  logic pin_q, pin_d, pin_fall, pin_rise;
  logic [NUM_CMD-1:0] cmd;
  logic done;

  // either reset source restarts the block
  assign rst = sys_rst_i || !module_rst_n_i;

  // commands are matched with case folding only in setup
  cmd_line_parser u_parser (
    .clk_i(clk_i),
    .sys_rst_i(rst),
    .byte_valid_i(rx_valid_i),
    .byte_i(rx_data_i),
    .fold_case_i(mode_q == OP_SETUP),
    .cmd_o(cmd)
  );

  assign win_done = (tmr_q == WIN_END);
  assign pin_fall = pin_q && !mode_sel_i;
  assign pin_rise = !pin_q && mode_sel_i;
  assign total = NOTICE_LEN[ntc_q] + FRAME_EXTRA;

  // notice framing: prefix, body, then cr lf
  always_comb begin
    if (bi_q == 5'h00) begin
      next_byte = CH_A;
    end else if (bi_q == 5'h01) begin
      next_byte = CH_T;
    end else if (bi_q == 5'h02) begin
      next_byte = CH_PLUS;
    end else if (bi_q < PREFIX_LEN + NOTICE_LEN[ntc_q]) begin
      next_byte = NOTICE_TEXT[ntc_q][127 - 8*int'(bi_q - PREFIX_LEN) -: 8];
    end else if (bi_q == PREFIX_LEN + NOTICE_LEN[ntc_q]) begin
      next_byte = CH_CR;
    end else begin
      next_byte = CH_LF;
    end
  end

  // state, notice and lock control
  always_comb begin
    mode_d = mode_q;
    tgt_d = tgt_q;
    phase_d = phase_q;
    ntc_d = ntc_q;
    bi_d = bi_q;
    tx_valid_d = tx_valid_q;
    tx_data_d = tx_data_q;
    lock_d = lock_q;
    tmr_d = tmr_q;
    save_d = 1'b0;
    load_d = 1'b0;
    done = 1'b0;
    pin_d = mode_sel_i;
    // the window only runs in the loader and then holds
    if (mode_q == OP_LOADER && !win_done) begin
      tmr_d = tmr_q + TW'(1);
    end
    unique case (phase_q)
      PH_IDLE: begin
        unique case (mode_q)
          OP_LOADER: begin
            if (cmd[CMD_HOLD_ON]) begin
              lock_d = 1'b1;
            end else if (cmd[CMD_HOLD_OFF]) begin
              lock_d = 1'b0;
            end else if (win_done && !lock_q && mode_sel_i &&
                         fw_ok_i) begin
              mode_d = OP_RUN;
              load_d = 1'b1;
              phase_d = PH_BEGIN;
              ntc_d = NT_OPER_BEGIN;
              bi_d = '0;
            end
          end
          OP_RUN: begin
            if (pin_fall || cmd[CMD_SETUP_ON]) begin
              phase_d = PH_END;
              ntc_d = NT_OPER_END;
              tgt_d = OP_SETUP;
              bi_d = '0;
            end
          end
          OP_SETUP: begin
            if (cmd[CMD_HOLD_ON]) begin
              lock_d = 1'b1;
            end else if (cmd[CMD_HOLD_OFF]) begin
              lock_d = 1'b0;
            end else if (cmd[CMD_RESTART_LDR]) begin
              lock_d = 1'b1;
              phase_d = PH_END;
              ntc_d = NT_SETUP_END;
              tgt_d = OP_LOADER;
              bi_d = '0;
            end else if (cmd[CMD_RESTART]) begin
              // plain restart: lock cleared, only the pin or a failed firmware check then holds the loader
              lock_d = 1'b0;
              phase_d = PH_END;
              ntc_d = NT_SETUP_END;
              tgt_d = OP_LOADER;
              bi_d = '0;
            end else if ((pin_rise || cmd[CMD_SETUP_OFF]) &&
                         !lock_q) begin
              phase_d = PH_END;
              ntc_d = NT_SETUP_END;
              tgt_d = OP_RUN;
              bi_d = '0;
            end
          end
          default: mode_d = OP_LOADER;
        endcase
      end
      PH_END, PH_BEGIN: begin
        if (!tx_valid_q || tx_ready_i) begin
          if (bi_q < total) begin
            tx_valid_d = 1'b1;
            tx_data_d = next_byte;
            bi_d = bi_q + 5'h01;
          end else begin
            // last byte must be gone before the baud may move
            tx_valid_d = 1'b0;
            done = !tx_valid_q;
          end
        end
        if (done && phase_q == PH_END) begin
          mode_d = tgt_q;
          phase_d = PH_BEGIN;
          bi_d = '0;
          save_d = (mode_q == OP_SETUP);
          load_d = (tgt_q == OP_RUN);
          unique case (tgt_q)
            OP_RUN: ntc_d = NT_OPER_BEGIN;
            OP_SETUP: ntc_d = NT_SETUP_BEGIN;
            default: begin
              ntc_d = NT_LOADER_BEGIN;
              tmr_d = '0;
            end
          endcase
        end else if (done) begin
          phase_d = PH_IDLE;
        end
      end
      default: phase_d = PH_IDLE;
    endcase
    // loader and setup pin the baud, run takes the stored value
    if (mode_d == OP_RUN) begin
      baud_d = load_d ? stored_baud_i : baud_q;
    end else begin
      baud_d = BAUD_FIXED;
    end
    stream_d = (mode_d == OP_RUN) && (phase_d == PH_IDLE);
  end

  // restart lands in the loader with its begin notice queued
  always_ff @(posedge clk_i) begin
    if (rst) begin
      mode_q <= OP_LOADER;
      tgt_q <= OP_LOADER;
      phase_q <= PH_BEGIN;
      ntc_q <= NT_LOADER_BEGIN;
      bi_q <= '0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      lock_q <= 1'b0;
      tmr_q <= '0;
      baud_q <= BAUD_FIXED;
      stream_q <= 1'b0;
      save_q <= 1'b0;
      load_q <= 1'b0;
      pin_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      tgt_q <= tgt_d;
      phase_q <= phase_d;
      ntc_q <= ntc_d;
      bi_q <= bi_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q <= tx_data_d;
      lock_q <= lock_d;
      tmr_q <= tmr_d;
      baud_q <= baud_d;
      stream_q <= stream_d;
      save_q <= save_d;
      load_q <= load_d;
      pin_q <= pin_d;
    end
  end

  assign tx_valid_o = tx_valid_q;
  assign tx_data_o = tx_data_q;
  assign baud_sel_o = baud_q;
  assign op_state_o = mode_q;
  assign lock_o = lock_q;
  assign stream_en_o = stream_q;
  assign nvm_save_o = save_q;
  assign settings_load_o = load_q;

  property p_reset_loader;
    @(posedge clk_i)
    rst |=> (mode_q == OP_LOADER && phase_q == PH_BEGIN &&
             ntc_q == NT_LOADER_BEGIN && !lock_q);
  endproperty
  a_reset_loader: assert property (p_reset_loader)
    else $error("restart did not enter the loader with its notice");

  property p_fixed_baud;
    @(posedge clk_i) disable iff (rst)
    (mode_q != OP_RUN) |-> (baud_sel_o == BAUD_FIXED && !stream_en_o);
  endproperty
  a_fixed_baud: assert property (p_fixed_baud)
    else $error("loader or setup not at the fixed baud");

  property p_window;
    @(posedge clk_i) disable iff (rst)
    (mode_q == OP_LOADER && !win_done) |=> (mode_q == OP_LOADER);
  endproperty
  a_window: assert property (p_window)
    else $error("loader left before its window ended");

  property p_pin_hold;
    @(posedge clk_i) disable iff (rst)
    (mode_q == OP_LOADER && (!mode_sel_i || lock_q)) |=>
      (mode_q == OP_LOADER);
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("loader left while held by pin or lock");

  property p_fw_check;
    @(posedge clk_i) disable iff (rst)
    (mode_q == OP_LOADER && !fw_ok_i) |=> (mode_q == OP_LOADER);
  endproperty
  a_fw_check: assert property (p_fw_check)
    else $error("loader left without firmware integrity");

  property p_run_notice;
    @(posedge clk_i) disable iff (rst)
    (mode_q == OP_RUN && $past(mode_q) != OP_RUN) |->
      (phase_q == PH_BEGIN && ntc_q == NT_OPER_BEGIN && settings_load_o);
  endproperty
  a_run_notice: assert property (p_run_notice)
    else $error("run entered without begin notice or settings load");

  property p_setup_save;
    @(posedge clk_i) disable iff (rst)
    ($past(mode_q) == OP_SETUP && mode_q != OP_SETUP) |->
      (nvm_save_o && $past(ntc_q) == NT_SETUP_END);
  endproperty
  a_setup_save: assert property (p_setup_save)
    else $error("setup left without save or end notice");

  property p_baud_steady;
    @(posedge clk_i) disable iff (rst)
    tx_valid_o |=> $stable(baud_sel_o);
  endproperty
  a_baud_steady: assert property (p_baud_steady)
    else $error("baud moved while a notice byte was pending");

  property p_setup_lock;
    @(posedge clk_i) disable iff (rst)
    (mode_q == OP_SETUP && lock_q && phase_q == PH_IDLE &&
     !cmd[CMD_RESTART_LDR] && !cmd[CMD_RESTART]) |=>
      (phase_q == PH_IDLE || tgt_q != OP_RUN);
  endproperty
  a_setup_lock: assert property (p_setup_lock)
    else $error("locked setup started a return to run");

endmodule : operating_state_sequencer
`default_nettype wire

// *** tb/host_model.sv ***
// Purpose: host side model, sends command lines and drives the mode pin
// Assumes: bytes go in deframed, one per strobe, uart framing elsewhere
// Notes: keeps each notice byte with the baud code it left at
`timescale 1ns/1ns
`default_nettype none
module host_model
  import seq_pkg::*;
(
  // clock
  input wire logic clk_i,
  // command bytes and mode pin
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic mode_sel_o,
  // notice bytes
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic [1:0] baud_sel_i,
  output logic tx_ready_o
);
  logic slow;
  logic stall_q;
  logic [7:0] got_q[$];
  logic [1:0] baud_q[$];

  // idle host, pin released high
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    mode_sel_o = 1'b1;
    slow = 1'b0;
    stall_q = 1'b0;
  end

  // slow mode drops ready on every other cycle, like a busy transmitter
  always @(negedge clk_i) begin
    stall_q <= slow & ~stall_q;
  end
  assign tx_ready_o = ~stall_q;

  // record every accepted byte with the baud in force
  always @(posedge clk_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
      got_q.push_back(tx_data_i);
      baud_q.push_back(baud_sel_i);
    end
  end

  task automatic put_byte(input logic [7:0] b);
    @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_data_o = b;
  endtask : put_byte

  // one line; lower folds body letters, term adds a line feed
  task automatic send_cmd(input int c, input bit lower, input bit term);
    logic [7:0] b;
    put_byte(CH_A);
    put_byte(CH_T);
    put_byte(CH_PLUS);
    for (int k = 0; k < int'(CMD_LEN[c]); k++) begin
      b = CMD_TEXT[c][8*CMD_MAX-1-8*k -: 8];
      if (lower && b >= 8'h41 && b <= 8'h5a) begin
        b = b | CASE_BIT;
      end
      put_byte(b);
    end
    if (term) begin
      put_byte(CH_LF);
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o; // released line shows no stale byte
  endtask : send_cmd

  // pin level; low holds loader or asks for setup
  task automatic set_pin(input logic v);
    @(negedge clk_i);
    mode_sel_o = v;
  endtask : set_pin
endmodule : host_model
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: self checking bench for the operating state sequencer
// Assumes: host_model stands on the serial side
// Notes: loader window shortened to WIN cycles
`timescale 1ns/1ns
`default_nettype none
module testbench
  import seq_pkg::*;
;
  localparam int unsigned WIN = 200;
  logic clk_i, sys_rst_i, module_rst_n_i, fw_ok_i, rx_valid_i, mode_sel_i;
  logic tx_ready_i, tx_valid_o, lock_o, stream_en_o, nvm_save_o;
  logic settings_load_o;
  logic [7:0] rx_data_i, tx_data_o;
  logic [1:0] stored_baud_i, baud_sel_o, op_state_o;
  int errors, checked, loads, saves;

  operating_state_sequencer #(.LOADER_WINDOW_CYC(WIN)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .module_rst_n_i(module_rst_n_i),
    .mode_sel_i(mode_sel_i), .fw_ok_i(fw_ok_i),
    .stored_baud_i(stored_baud_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i), .baud_sel_o(baud_sel_o),
    .op_state_o(op_state_o), .lock_o(lock_o), .stream_en_o(stream_en_o),
    .nvm_save_o(nvm_save_o), .settings_load_o(settings_load_o)
  );

  host_model host_u (
    .clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
    .mode_sel_o(mode_sel_i), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .baud_sel_i(baud_sel_o), .tx_ready_o(tx_ready_i)
  );

  // 250 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // pulse counters for load and save strobes
  always @(posedge clk_i) begin
    if (settings_load_o === 1'b1) loads++;
    if (nvm_save_o === 1'b1) saves++;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // bounded wait for a state, a stuck state ends the run
  task automatic wait_state(input logic [1:0] s);
    int n;
    n = 0;
    while (op_state_o !== s && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check(8'(op_state_o), 8'(s), "state");
    if (n >= 3000) give_verdict();
  endtask : wait_state

  // whole notice compared byte by byte with its baud code
  task automatic expect_notice(input int i, input logic [1:0] bd);
    logic [7:0] e;
    int n, len;
    n = 0;
    len = int'(NOTICE_LEN[i]);
    while (host_u.got_q.size() < len + 5 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      check(8'h00, 8'h01, "notice missing");
      give_verdict();
    end
    for (int k = 0; k < len + 5; k++) begin
      if (k == 0) e = CH_A;
      else if (k == 1) e = CH_T;
      else if (k == 2) e = CH_PLUS;
      else if (k < len + 3) e = NOTICE_TEXT[i][127-8*(k-3) -: 8];
      else if (k == len + 3) e = CH_CR;
      else e = CH_LF;
      check(host_u.got_q.pop_front(), e, "notice byte");
      check(8'(host_u.baud_q.pop_front()), 8'(bd), "notice baud");
    end
    repeat (4) @(negedge clk_i);
  endtask : expect_notice

  task automatic do_reset(input logic pin, input logic fw, input bit by_pin);
    @(negedge clk_i);
    if (by_pin) module_rst_n_i = 1'b0;
    else sys_rst_i = 1'b1;
    host_u.mode_sel_o = pin;
    fw_ok_i = fw;
    repeat (4) @(negedge clk_i);
    check(8'(op_state_o), 8'(OP_LOADER), "reset state");
    check({6'h0, lock_o, stream_en_o}, 8'h00, "reset flags");
    sys_rst_i = 1'b0;
    module_rst_n_i = 1'b1;
    host_u.got_q.delete();
    host_u.baud_q.delete();
    expect_notice(NT_LOADER_BEGIN, BAUD_FIXED);
  endtask : do_reset

  // refused lines in loader, then the window runs out into run
  task automatic t_boot_auto();
    loads = 0;
    host_u.send_cmd(CMD_HOLD_ON, 1'b1, 1'b1);
    host_u.send_cmd(CMD_HOLD_ON, 1'b0, 1'b0);
    repeat (4) @(negedge clk_i);
    check(8'(lock_o), 8'h00, "lock after refused lines");
    wait_state(OP_RUN);
    expect_notice(NT_OPER_BEGIN, 2'h1);
    check(8'(baud_sel_o), 8'h01, "run baud");
    check(8'(stream_en_o), 8'h01, "streaming");
    check(8'(loads), 8'h01, "load pulse");
    $display("test boot_auto done");
  endtask : t_boot_auto

  // hold command locks the loader past the window, clearing lets go
  task automatic t_lock_loader();
    do_reset(1'b1, 1'b1, 1'b1);
    host_u.send_cmd(CMD_HOLD_ON, 1'b0, 1'b1);
    repeat (4) @(negedge clk_i);
    check(8'(lock_o), 8'h01, "lock set");
    repeat (WIN + 50) @(negedge clk_i);
    check(8'(op_state_o), 8'(OP_LOADER), "locked loader");
    host_u.send_cmd(CMD_HOLD_OFF, 1'b0, 1'b1);
    wait_state(OP_RUN);
    check(8'(lock_o), 8'h00, "lock cleared");
    expect_notice(NT_OPER_BEGIN, 2'h1);
    $display("test lock_loader done");
  endtask : t_lock_loader

  // pin low at start, then bad firmware, both keep the loader
  task automatic t_pin_fw();
    do_reset(1'b0, 1'b0, 1'b0);
    repeat (WIN + 50) @(negedge clk_i);
    check(8'(op_state_o), 8'(OP_LOADER), "pin hold");
    host_u.set_pin(1'b1);
    repeat (WIN + 50) @(negedge clk_i);
    check(8'(op_state_o), 8'(OP_LOADER), "bad firmware");
    stored_baud_i = 2'h2;
    fw_ok_i = 1'b1;
    wait_state(OP_RUN);
    expect_notice(NT_OPER_BEGIN, 2'h2);
    $display("test pin_fw done");
  endtask : t_pin_fw

  // pin round trip through setup with a stalling transmitter
  task automatic t_pin_setup();
    host_u.slow = 1'b1;
    loads = 0;
    saves = 0;
    host_u.set_pin(1'b0);
    expect_notice(NT_OPER_END, 2'h2);
    expect_notice(NT_SETUP_BEGIN, BAUD_FIXED);
    wait_state(OP_SETUP);
    check({6'h0, baud_sel_o}, 8'h00, "setup baud");
    check(8'(stream_en_o), 8'h00, "setup halts");
    host_u.set_pin(1'b1);
    expect_notice(NT_SETUP_END, BAUD_FIXED);
    expect_notice(NT_OPER_BEGIN, 2'h2);
    wait_state(OP_RUN);
    check(8'(saves), 8'h01, "save pulse");
    check(8'(loads), 8'h01, "load pulse");
    host_u.slow = 1'b0;
    $display("test pin_setup done");
  endtask : t_pin_setup

  // command path into setup, lock there, restart into a locked loader
  task automatic t_cmd_setup();
    saves = 0;
    host_u.send_cmd(CMD_SETUP_ON, 1'b0, 1'b1);
    expect_notice(NT_OPER_END, 2'h2);
    expect_notice(NT_SETUP_BEGIN, BAUD_FIXED);
    wait_state(OP_SETUP);
    host_u.send_cmd(CMD_HOLD_ON, 1'b1, 1'b1);
    repeat (4) @(negedge clk_i);
    check(8'(lock_o), 8'h01, "setup lock");
    host_u.send_cmd(CMD_SETUP_OFF, 1'b0, 1'b1);
    repeat (WIN) @(negedge clk_i);
    check(8'(op_state_o), 8'(OP_SETUP), "locked setup");
    host_u.send_cmd(CMD_RESTART_LDR, 1'b0, 1'b1);
    expect_notice(NT_SETUP_END, BAUD_FIXED);
    expect_notice(NT_LOADER_BEGIN, BAUD_FIXED);
    wait_state(OP_LOADER);
    check(8'(lock_o), 8'h01, "loader lock");
    check(8'(saves), 8'h01, "save on exit");
    repeat (WIN + 50) @(negedge clk_i);
    check(8'(op_state_o), 8'(OP_LOADER), "stays loader");
    $display("test cmd_setup done");
  endtask : t_cmd_setup

  // unlock into run, pin into setup, plain restart held by the pin
  task automatic t_restart();
    saves = 0;
    host_u.send_cmd(CMD_HOLD_OFF, 1'b0, 1'b1);
    wait_state(OP_RUN);
    expect_notice(NT_OPER_BEGIN, 2'h2);
    host_u.set_pin(1'b0);
    expect_notice(NT_OPER_END, 2'h2);
    expect_notice(NT_SETUP_BEGIN, BAUD_FIXED);
    host_u.send_cmd(CMD_HOLD_ON, 1'b0, 1'b1);
    host_u.send_cmd(CMD_HOLD_OFF, 1'b0, 1'b1);
    repeat (4) @(negedge clk_i);
    check(8'(lock_o), 8'h00, "setup unlock");
    host_u.send_cmd(CMD_RESTART, 1'b1, 1'b1);
    expect_notice(NT_SETUP_END, BAUD_FIXED);
    expect_notice(NT_LOADER_BEGIN, BAUD_FIXED);
    check(8'(saves), 8'h01, "save on restart");
    repeat (WIN + 50) @(negedge clk_i);
    check(8'(op_state_o), 8'(OP_LOADER), "pin hold restart");
    check(8'(lock_o), 8'h00, "restart no lock");
    host_u.set_pin(1'b1);
    wait_state(OP_RUN);
    expect_notice(NT_OPER_BEGIN, 2'h2);
    $display("test restart done");
  endtask : t_restart

  // main sequence
  initial begin
    errors = 0;
    checked = 0;
    sys_rst_i = 1'b1;
    module_rst_n_i = 1'b1;
    fw_ok_i = 1'b1;
    stored_baud_i = 2'h1;
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'b0;
    expect_notice(NT_LOADER_BEGIN, BAUD_FIXED);
    t_boot_auto();
    t_lock_loader();
    t_pin_fw();
    t_pin_setup();
    t_cmd_setup();
    t_restart();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
